// ===== hw/ccr_config_regs.sv
// Charger configuration register bank with host-link watchdog and interrupt events
//
// Summary of operation
// (R01) Watchdog limit code 00 off, 01 40s, 10 80s, 11 160s; default 01; kept on expiry.
// (R02) Limit code 00 keeps the watchdog stopped even in discharge mode.
// (R03) Bit 7 lets the watchdog run in discharge mode; default 0; kept on expiry.
// (R04) Termination allowed only while termination enable is 1; default 1.
// (R05) Safety timer runs only while its enable bit is 1; default 1.
// (R06) Fast-charge timer code 00 3h, 01 5h, 10 8h, 11 12h; default 01.
// (R07) Termination timer bit 1 keeps charge current after termination; default 0.
// (R08) Timer doubling bit 1 doubles the safety timer during power-path limiting.
// (R09) Battery switch shutoff 1 turns battery switch off; default 0; kept on expiry.
// (R10) Five interrupt masks, 0 enables, 1 suppresses; all default 0.
// (R11) Charge-state interrupt fires on changes among idle, pre-charge, fast-charge unless masked.
// (R12) Thermal threshold code 00 60C, 01 80C, 10 100C, 11 120C; default 11.
// (R13) System voltage is 4.2V plus 50mV per step; default 1001; kept on expiry.
// (R14) Host must issue a watchdog reset after expiry before the watchdog runs again.
// (R15) Expiry restores watchdog-resettable fields to defaults, others unchanged.
// (R16) Board over-temperature and input loop active when their bits are 0.
`timescale 1ns/1ns
`include "ccr_defs.svh"
module ccr_config_regs
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `CCR_WD_TICK_MS * (`CCR_CLK_HZ / 1000),
   parameter int unsigned TICK_W = 24
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rdata,
   input wire logic soft_reset,
   input wire logic watchdog_reset,
   input wire logic discharge_mode,
   input wire logic power_path_limiting,
   input wire logic power_good,
   input wire logic [1:0] charge_state,
   input wire logic [1:0] thermistor_fault,
   input wire logic battery_overvoltage,
   output ccr_cfg_t cfg,
   output ccr_irq_t irq_event,
   output logic host_timeout_expiry,
   output logic watchdog_fault
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   ccr_wdt_reg_t wdt;
   ccr_wdt_reg_t next_wdt;
   ccr_prot_reg_t prot;
   ccr_prot_reg_t next_prot;
   ccr_thsv_reg_t thsv;
   ccr_thsv_reg_t next_thsv;
   logic [7:0] next_rdata;
   logic wd_expire;

   function automatic logic [7:0] restore(input logic [7:0] cur, input logic [7:0] def,
                                          input logic [7:0] mask);
      restore = (cur & ~mask) | (def & mask);
   endfunction

   always_comb begin
      next_wdt = wdt;
      next_prot = prot;
      next_thsv = thsv;
      if (soft_reset) begin
         next_wdt = ccr_wdt_reg_t'(`CCR_DEF_WDT);
         next_prot = ccr_prot_reg_t'(`CCR_DEF_PROT);
         next_thsv = ccr_thsv_reg_t'(`CCR_DEF_THSV);
      end else begin
         if (wr_strobe) begin
            case (addr)
               `CCR_OFF_WDT: next_wdt = ccr_wdt_reg_t'(wdata);
               `CCR_OFF_PROT: next_prot = ccr_prot_reg_t'(wdata);
               `CCR_OFF_THSV: next_thsv = ccr_thsv_reg_t'(wdata);
               default: next_wdt = wdt;
            endcase
         end
         // Expiry lands after a same-cycle write so the restore is never undone
         if (wd_expire) begin
            next_wdt = ccr_wdt_reg_t'(restore(next_wdt, `CCR_DEF_WDT, `CCR_EXP_MASK_WDT)); // see (R15) (R01) (R03)
            next_prot = ccr_prot_reg_t'(restore(next_prot, `CCR_DEF_PROT, `CCR_EXP_MASK_PROT)); // see (R15) (R09)
            next_thsv = ccr_thsv_reg_t'(restore(next_thsv, `CCR_DEF_THSV, `CCR_EXP_MASK_THSV)); // see (R15) (R13)
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wdt <= ccr_wdt_reg_t'(`CCR_DEF_WDT); // see (R01) (R03) (R04) (R05) (R06) (R07)
         prot <= ccr_prot_reg_t'(`CCR_DEF_PROT); // see (R08) (R09) (R10)
         thsv <= ccr_thsv_reg_t'(`CCR_DEF_THSV); // see (R12) (R13) (R16)
      end else begin
         wdt <= next_wdt;
         prot <= next_prot;
         thsv <= next_thsv;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   ccr_wd_state_t wd_state;
   ccr_wd_state_t next_wd_state;

   always_comb begin
      next_rdata = 8'h00;
      if (rd_strobe) begin
         case (addr)
            `CCR_OFF_WDT: next_rdata = wdt;
            `CCR_OFF_PROT: next_rdata = prot;
            `CCR_OFF_THSV: next_rdata = thsv;
            `CCR_OFF_STAT: begin
               next_rdata[`CCR_STAT_FAULT_BIT] = (wd_state == CCR_WD_EXPIRED);
               next_rdata[`CCR_STAT_RUN_BIT] = (wd_state == CCR_WD_RUN);
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Host-link watchdog
   // ----------------------------------------
   // Any register write counts as host activity and restarts the count, except a write in the cycle whose tick expires the watchdog.
   logic [TICK_W-1:0] tick_cnt;
   logic [TICK_W-1:0] next_tick_cnt;
   logic [7:0] sec_cnt;
   logic [7:0] next_sec_cnt;
   logic [7:0] limit_s;
   logic wd_allowed;
   logic tick;
   logic restart;

   always_comb begin
      case (wdt.watchdog_limit)
         `CCR_WD_OFF: limit_s = 8'h00;
         `CCR_WD_CODE_40: limit_s = `CCR_WD_S_40;
         `CCR_WD_CODE_80: limit_s = `CCR_WD_S_80;
         default: limit_s = `CCR_WD_S_160;
      endcase
   end

   // Code 00 stops the timer whatever the discharge enable says
   assign wd_allowed = (wdt.watchdog_limit != `CCR_WD_OFF) && // see (R02)
                       (!discharge_mode || wdt.discharge_watchdog_enable); // see (R03)
   assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
   assign restart = watchdog_reset || wr_strobe;

   always_comb begin
      next_wd_state = wd_state;
      next_tick_cnt = tick_cnt;
      next_sec_cnt = sec_cnt;
      wd_expire = 1'b0;
      case (wd_state)
         CCR_WD_IDLE: begin
            next_tick_cnt = '0;
            next_sec_cnt = 8'h00;
            if (wd_allowed) begin
               next_wd_state = CCR_WD_RUN;
            end
         end
         CCR_WD_RUN: begin
            if (!wd_allowed) begin
               next_wd_state = CCR_WD_IDLE;
            end else if (tick && (sec_cnt + 8'h01 >= limit_s)) begin
               wd_expire = 1'b1; // see (R01)
               next_wd_state = CCR_WD_EXPIRED;
            end else if (restart) begin
               next_tick_cnt = '0;
               next_sec_cnt = 8'h00;
            end else if (tick) begin
               next_tick_cnt = '0;
               next_sec_cnt = sec_cnt + 8'h01;
            end else begin
               next_tick_cnt = tick_cnt + TICK_W'(1);
            end
         end
         CCR_WD_EXPIRED: begin
            // Stays halted until the host resets the watchdog explicitly
            next_tick_cnt = '0;
            next_sec_cnt = 8'h00;
            if (watchdog_reset) begin
               next_wd_state = CCR_WD_IDLE; // see (R14)
            end
         end
         default: next_wd_state = CCR_WD_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wd_state <= CCR_WD_IDLE;
         tick_cnt <= '0;
         sec_cnt <= 8'h00;
         host_timeout_expiry <= 1'b0;
         watchdog_fault <= 1'b0;
      end else begin
         wd_state <= next_wd_state;
         tick_cnt <= next_tick_cnt;
         sec_cnt <= next_sec_cnt;
         host_timeout_expiry <= wd_expire;
         watchdog_fault <= (next_wd_state == CCR_WD_EXPIRED);
      end
   end

   // ----------------------------------------
   // Decoded configuration
   // ----------------------------------------
   ccr_cfg_t next_cfg;
   logic [4:0] fc_hours;

   always_comb begin
      case (wdt.fast_charge_time_limit)
         `CCR_FC_CODE_3: fc_hours = `CCR_FC_H_3; // see (R06)
         `CCR_FC_CODE_5: fc_hours = `CCR_FC_H_5;
         `CCR_FC_CODE_8: fc_hours = `CCR_FC_H_8;
         default: fc_hours = `CCR_FC_H_12;
      endcase
      next_cfg.termination_allowed = wdt.termination_enable; // see (R04)
      next_cfg.safety_timer_run = wdt.safety_timer_enable; // see (R05)
      next_cfg.post_termination_charge_keep = wdt.post_termination_charge_keep; // see (R07)
      next_cfg.battery_switch_off = prot.battery_switch_shutoff; // see (R09)
      next_cfg.thermistor_monitor_on = prot.thermistor_monitor_enable;
      next_cfg.board_overtemp_on = !thsv.board_overtemp_disable; // see (R16)
      next_cfg.input_loop_on = !thsv.input_loop_disable; // see (R16)
      // Doubling only while the input path is being limited
      if (prot.timer_doubling_enable && power_path_limiting) begin
         next_cfg.safety_timer_hours = {fc_hours[3:0], 1'b0}; // see (R08)
      end else begin
         next_cfg.safety_timer_hours = fc_hours;
      end
      case (thsv.thermal_threshold)
         `CCR_TJ_CODE_60: next_cfg.thermal_threshold_c = `CCR_TJ_C_60; // see (R12)
         `CCR_TJ_CODE_80: next_cfg.thermal_threshold_c = `CCR_TJ_C_80;
         `CCR_TJ_CODE_100: next_cfg.thermal_threshold_c = `CCR_TJ_C_100;
         default: next_cfg.thermal_threshold_c = `CCR_TJ_C_120;
      endcase
      next_cfg.system_voltage_mv = `CCR_VSYS_BASE_MV +
         13'(`CCR_VSYS_STEP_MV * 13'(thsv.system_voltage_target)); // see (R13)
      next_cfg.watchdog_limit_s = limit_s; // see (R01)
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   // Status inputs come from charger logic on this clock, so no synchroniser.
   // The first cycle after reset is ignored so power-up levels raise no event.
   logic primed;
   logic pg_q;
   logic [1:0] cs_q;
   logic [1:0] ntc_q;
   logic ovp_q;
   ccr_irq_t next_irq;
   logic cs_old_active;
   logic cs_new_active;

   assign cs_old_active = (cs_q != `CCR_CHG_DONE);
   assign cs_new_active = (charge_state != `CCR_CHG_DONE);

   always_comb begin
      next_irq = '0;
      if (primed) begin
         next_irq.power_good = (power_good != pg_q) && !prot.power_good_irq_mask; // see (R10)
         next_irq.charge_done = (charge_state == `CCR_CHG_DONE) && cs_old_active &&
                                !prot.charge_done_irq_mask; // see (R10)
         next_irq.charge_state = (charge_state != cs_q) && cs_old_active && cs_new_active &&
                                 !prot.charge_state_irq_mask; // see (R11)
         next_irq.thermistor = (thermistor_fault != ntc_q) && !prot.thermistor_irq_mask; // see (R10)
         next_irq.battery_overvoltage = battery_overvoltage && !ovp_q &&
                                        !prot.battery_overvoltage_irq_mask; // see (R10)
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         primed <= 1'b0;
         pg_q <= 1'b0;
         cs_q <= 2'h0;
         ntc_q <= 2'h0;
         ovp_q <= 1'b0;
         irq_event <= '0;
      end else begin
         primed <= 1'b1;
         pg_q <= power_good;
         cs_q <= charge_state;
         ntc_q <= thermistor_fault;
         ovp_q <= battery_overvoltage;
         irq_event <= next_irq;
      end
   end

endmodule

// ===== hw/ccr_defs.svh
// Offsets, field codes, defaults and timing for the charger configuration bank
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCR_OFF_WDT 8'h05
`define CCR_OFF_PROT 8'h06
`define CCR_OFF_THSV 8'h07
`define CCR_OFF_STAT 8'h0b
// ----------------------------------------
// Defaults and watchdog-restore masks
// ----------------------------------------
`define CCR_DEF_WDT 8'h3a
`define CCR_DEF_PROT 8'hc0
`define CCR_DEF_THSV 8'h39
`define CCR_EXP_MASK_WDT 8'h1f
`define CCR_EXP_MASK_PROT 8'hdf
`define CCR_EXP_MASK_THSV 8'hf0
`define CCR_STAT_FAULT_BIT 7
`define CCR_STAT_RUN_BIT 6
// ----------------------------------------
// Field codes and decoded values
// ----------------------------------------
`define CCR_WD_OFF 2'h0
`define CCR_WD_CODE_40 2'h1
`define CCR_WD_CODE_80 2'h2
`define CCR_WD_S_40 8'h28
`define CCR_WD_S_80 8'h50
`define CCR_WD_S_160 8'ha0
`define CCR_FC_CODE_3 2'h0
`define CCR_FC_CODE_5 2'h1
`define CCR_FC_CODE_8 2'h2
`define CCR_FC_H_3 5'h03
`define CCR_FC_H_5 5'h05
`define CCR_FC_H_8 5'h08
`define CCR_FC_H_12 5'h0c
`define CCR_TJ_CODE_60 2'h0
`define CCR_TJ_CODE_80 2'h1
`define CCR_TJ_CODE_100 2'h2
`define CCR_TJ_C_60 7'h3c
`define CCR_TJ_C_80 7'h50
`define CCR_TJ_C_100 7'h64
`define CCR_TJ_C_120 7'h78
`define CCR_VSYS_BASE_MV 13'h1068
`define CCR_VSYS_STEP_MV 13'h0032
`define CCR_CHG_DONE 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define CCR_CLK_HZ 10000000
`define CCR_WD_TICK_MS 1000
`endif

// ===== hw/ccr_pkg.sv
// Types shared by the charger configuration bank
package ccr_pkg;
   typedef struct packed {
      logic discharge_watchdog_enable;
      logic [1:0] watchdog_limit;
      logic termination_enable;
      logic safety_timer_enable;
      logic [1:0] fast_charge_time_limit;
      logic post_termination_charge_keep;
   } ccr_wdt_reg_t;
   typedef struct packed {
      logic thermistor_monitor_enable;
      logic timer_doubling_enable;
      logic battery_switch_shutoff;
      logic power_good_irq_mask;
      logic charge_done_irq_mask;
      logic charge_state_irq_mask;
      logic thermistor_irq_mask;
      logic battery_overvoltage_irq_mask;
   } ccr_prot_reg_t;
   typedef struct packed {
      logic board_overtemp_disable;
      logic input_loop_disable;
      logic [1:0] thermal_threshold;
      logic [3:0] system_voltage_target;
   } ccr_thsv_reg_t;
   typedef struct packed {
      logic power_good;
      logic charge_done;
      logic charge_state;
      logic thermistor;
      logic battery_overvoltage;
   } ccr_irq_t;
   typedef struct packed {
      logic termination_allowed;
      logic safety_timer_run;
      logic post_termination_charge_keep;
      logic battery_switch_off;
      logic thermistor_monitor_on;
      logic board_overtemp_on;
      logic input_loop_on;
      logic [4:0] safety_timer_hours;
      logic [6:0] thermal_threshold_c;
      logic [12:0] system_voltage_mv;
      logic [7:0] watchdog_limit_s;
   } ccr_cfg_t;
   typedef enum logic [2:0] {
      CCR_WD_IDLE = 3'b001,
      CCR_WD_RUN = 3'b010,
      CCR_WD_EXPIRED = 3'b100
   } ccr_wd_state_t;
endpackage

// ===== testbench/ccr_config_regs_sva.sv
// Concurrent checks on the charger configuration bank ports
`timescale 1ns/1ns
module ccr_config_regs_sva
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10,
   parameter int unsigned TICK_W = 24
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] rdata,
   input wire logic soft_reset,
   input wire logic watchdog_reset,
   input wire logic [1:0] charge_state,
   input wire logic battery_overvoltage,
   input wire ccr_cfg_t cfg,
   input wire ccr_irq_t irq_event,
   input wire logic host_timeout_expiry,
   input wire logic watchdog_fault
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_wr_vsys;
      wr_strobe && addr == 8'h07 && !soft_reset;
   endsequence
   sequence s_restored;
      cfg.termination_allowed && cfg.safety_timer_run && !cfg.post_termination_charge_keep &&
         cfg.thermistor_monitor_on && cfg.board_overtemp_on && cfg.input_loop_on && cfg.thermal_threshold_c == 7'h78;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   vsys_keep_a: assert property (s_wr_vsys ##1 !(wr_strobe || soft_reset) ##1 (rd_strobe && addr == 8'h07)
      |=> rdata[3:0] == $past(wdata[3:0], 3)) else $error("system voltage field read back wrong");
   wd_off_a: assert property (cfg.watchdog_limit_s == 8'h00 [*2] |=> !host_timeout_expiry)
      else $error("watchdog expired while its limit was off");
   expiry_restore_a: assert property (host_timeout_expiry |-> watchdog_fault ##1 s_restored)
      else $error("expiry did not restore defaults");
   fault_hold_a: assert property (watchdog_fault && !watchdog_reset && !$past(watchdog_reset) |=> watchdog_fault)
      else $error("watchdog fault dropped without a watchdog reset");
   expiry_pulse_a: assert property (host_timeout_expiry |=> !host_timeout_expiry)
      else $error("expiry pulse longer than one cycle");
   kept_fields_a: assert property (host_timeout_expiry && !$past(wr_strobe) && !$past(soft_reset) |-> ##1
      $stable(cfg.watchdog_limit_s) && $stable(cfg.system_voltage_mv) && $stable(cfg.battery_switch_off))
      else $error("expiry changed a field that must survive it");
   irq_state_a: assert property (irq_event.charge_state |-> $past(charge_state) != $past(charge_state, 2) &&
      $past(charge_state) != 2'h3 && $past(charge_state, 2) != 2'h3) else $error("charge state event without cause");
   irq_done_a: assert property (irq_event.charge_done |-> $past(charge_state) == 2'h3 &&
      $past(charge_state, 2) != 2'h3) else $error("charge done event without cause");
   irq_bov_a: assert property (irq_event.battery_overvoltage |-> $past(battery_overvoltage) &&
      !$past(battery_overvoltage, 2)) else $error("overvoltage event without a rise");
   decode_range_a: assert property ($past(rst_b) |->
      cfg.safety_timer_hours inside {5'h03, 5'h05, 5'h08, 5'h0c, 5'h06, 5'h0a, 5'h10, 5'h18} &&
      cfg.thermal_threshold_c inside {7'h3c, 7'h50, 7'h64, 7'h78}) else $error("decoded value out of its set");
endmodule
bind ccr_config_regs ccr_config_regs_sva #(.TICK_CYCLES(TICK_CYCLES), .TICK_W(TICK_W)) i_sva (.clock(clock),
   .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
   .soft_reset(soft_reset), .watchdog_reset(watchdog_reset), .charge_state(charge_state),
   .battery_overvoltage(battery_overvoltage), .cfg(cfg), .irq_event(irq_event),
   .host_timeout_expiry(host_timeout_expiry), .watchdog_fault(watchdog_fault));

// ===== testbench/testbench.sv
// Self-checking bench for the charger configuration bank
`timescale 1ns/1ns
module testbench
   import ccr_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_strobe = 1'b0, rd_strobe = 1'b0, soft_reset = 1'b0, watchdog_reset = 1'b0;
   logic discharge_mode = 1'b0, power_path_limiting = 1'b0, power_good = 1'b0, battery_overvoltage = 1'b0;
   logic [1:0] charge_state = 2'h0, thermistor_fault = 2'h0;
   logic [7:0] rdata, v;
   ccr_cfg_t cfg;
   ccr_irq_t irq_event;
   logic host_timeout_expiry, watchdog_fault;
   int miscompares = 0, check_count = 0, n;
   int m [16];
   // Short tick keeps a 40 s limit at 160 cycles
   ccr_config_regs #(.TICK_CYCLES(4), .TICK_W(24)) i_dut (.clock(clock), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .soft_reset(soft_reset),
      .watchdog_reset(watchdog_reset), .discharge_mode(discharge_mode), .power_path_limiting(power_path_limiting),
      .power_good(power_good), .charge_state(charge_state), .thermistor_fault(thermistor_fault),
      .battery_overvoltage(battery_overvoltage), .cfg(cfg), .irq_event(irq_event),
      .host_timeout_expiry(host_timeout_expiry), .watchdog_fault(watchdog_fault));
   always #50 clock = ~clock;
   // ----------------------------------------
   // Model and helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1'b1;
      @(posedge clock);
      wr_strobe <= 1'b0;
      if (a inside {[8'h05:8'h07]}) m[a] = d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clock);
      rd_strobe <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic ccr_cfg_t exp_cfg(input logic ppl);
      ccr_cfg_t c;
      logic [4:0] hrs [4] = '{5'h03, 5'h05, 5'h08, 5'h0c};
      c.termination_allowed = m[5][4];
      c.safety_timer_run = m[5][3];
      c.post_termination_charge_keep = m[5][0];
      c.battery_switch_off = m[6][5];
      c.thermistor_monitor_on = m[6][7];
      c.board_overtemp_on = !m[7][7];
      c.input_loop_on = !m[7][6];
      c.safety_timer_hours = hrs[m[5][2:1]] << (m[6][6] & ppl);
      c.thermal_threshold_c = 7'h3c + 7'h14 * m[7][5:4];
      c.system_voltage_mv = 13'h1068 + 13'h32 * m[7][3:0];
      c.watchdog_limit_s = m[5][6:5] == 0 ? 8'h00 : 8'h14 << m[5][6:5];
      return c;
   endfunction
   task automatic chk_all;
      repeat (2) @(posedge clock);
      #1 chk("cfg", exp_cfg(power_path_limiting), cfg);
      for (int a = 5; a < 8; a++) begin
         rd(8'(a), v);
         chk("rdata", m[a], v);
      end
   endtask
   // Mask bits line up with the event struct, so one AND applies all five
   task automatic events(input logic [7:0] mk);
      logic [5:0] p;
      logic [4:0] e;
      wr(8'h06, mk);
      p = {power_good, charge_state, thermistor_fault, battery_overvoltage};
      repeat (40) begin
         @(posedge clock);
         e[4] = power_good != p[5];
         e[3] = charge_state == 2'h3 && p[4:3] != 2'h3;
         e[2] = charge_state != p[4:3] && charge_state != 2'h3 && p[4:3] != 2'h3;
         e[1] = thermistor_fault != p[2:1];
         e[0] = battery_overvoltage && !p[0];
         p = {power_good, charge_state, thermistor_fault, battery_overvoltage};
         {power_good, charge_state, thermistor_fault, battery_overvoltage} <= 6'($urandom);
         #1 chk("irq_event", e & ~m[6][4:0], irq_event);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h6f04));
      m = '{default: 0};
      m[5] = 'h3a;
      m[6] = 'hc0;
      m[7] = 'h39;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      // Ignored write goes first so the default check also proves it left the bank alone
      wr(8'h20, 8'hff);
      chk_all();
      rd(8'h10, v);
      chk("unmapped", 0, v);
      repeat (16) begin
         wr(8'h05, 8'($urandom));
         wr(8'h06, 8'($urandom));
         wr(8'h07, 8'($urandom));
         power_path_limiting <= 1'($urandom);
         chk_all();
      end
      events(8'h00);
      events(8'($urandom));
      discharge_mode <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         wr(8'h05, i ? 8'h3a : 8'h80);
         repeat (200) @(posedge clock);
         #1 chk("watchdog_fault", 0, watchdog_fault);
      end
      wr(8'h05, 8'ha5);
      wr(8'h06, 8'h3f);
      wr(8'h07, 8'hc5);
      n = 0;
      while (host_timeout_expiry !== 1'b1 && n < 1000) begin
         @(posedge clock);
         #1 n++;
      end
      chk("expiry_cycles", 1, n >= 157 && n <= 163);
      chk("watchdog_fault", 1, watchdog_fault);
      m[5] = (m[5] & 'he0) | 'h1a;
      m[6] = (m[6] & 'h20) | 'hc0;
      m[7] = (m[7] & 'h0f) | 'h30;
      chk_all();
      rd(8'h0b, v);
      chk("status", 2'b10, v[7:6]);
      @(posedge clock);
      watchdog_reset <= 1'b1;
      discharge_mode <= 1'b0;
      @(posedge clock);
      watchdog_reset <= 1'b0;
      repeat (3) @(posedge clock);
      #1 chk("watchdog_fault", 0, watchdog_fault);
      rd(8'h0b, v);
      chk("status", 2'b01, v[7:6]);
      wr(8'h07, 8'h00);
      rd(8'h07, v);
      chk("rdata", 0, v);
      @(posedge clock);
      soft_reset <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      m[5] = 'h3a;
      m[6] = 'hc0;
      m[7] = 'h39;
      chk_all();
      close_out();
   end
   initial begin
      #(100 * 20000);
      miscompares++;
      close_out();
   end
endmodule
